// >>> design/dct_pkg.sv
// Constants for the dual camera trigger and frame pairing block.
// Assumes a single 50 MHz system clock and a plain register port.
// Summary of operation
// - Two trigger outputs only: primary and secondary.
// - Each trigger has its own enable; disabled means no pulses.
// - Primary frequency programmable from 0.1 Hz to 50 Hz.
// - Primary pulse width programmable in milliseconds.
// - Pulses are active high, low again after the width.
// - Secondary only runs while the primary is enabled.
// - Secondary repeats at exactly the primary frequency.
// - Secondary rises a programmed offset after each primary rise.
// - Secondary has its own pulse width.
// - With pulse-per-second sync on, the secondary never pulses.
// - Trigger-time option stamps results with the primary trigger time.
// - Frames pair only if their stamps differ by at most the maximum.
// - Right feature following an automatic left feature copies the left value.
// - With pulse-per-second sync on, each sync pulse clears the timestamp clock.
package dct_pkg;
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned MS_US = 1000;
  localparam int unsigned TS_TICK_US = 1;
  // Cycles per millisecond and per timestamp microsecond
  localparam logic [31:0] CYC_PER_MS = 32'(CLK_HZ / 1000);
  localparam logic [31:0] CYC_PER_US = 32'(CLK_HZ / 1000000 * TS_TICK_US);
  // Period limits: 50 Hz and 0.1 Hz in cycles
  localparam logic [31:0] PER_MIN = 32'(CLK_HZ / 50);
  localparam logic [31:0] PER_MAX = 32'(CLK_HZ * 10);

  localparam logic [3:0] A_CTRL = 4'h0;
  localparam logic [3:0] A_PERIOD = 4'h1;
  localparam logic [3:0] A_W0_MS = 4'h2;
  localparam logic [3:0] A_W1_MS = 4'h3;
  localparam logic [3:0] A_OFS_MS = 4'h4;
  localparam logic [3:0] A_MAXDIFF = 4'h5;
  localparam logic [3:0] A_TSTAMP = 4'h6;
  localparam logic [3:0] A_LAST_TRIG = 4'h7;
  localparam logic [3:0] A_PAIR = 4'h8;
  localparam logic [3:0] A_FEAT = 4'h9;
  localparam logic [3:0] A_RIGHT_SET = 4'ha;

  localparam int unsigned B_EN0 = 0;
  localparam int unsigned B_EN1 = 1;
  localparam int unsigned B_PPS = 2;
  localparam int unsigned B_TTS = 3;
  localparam int unsigned B_FOLLOW = 4;
  localparam int unsigned B_LAUTO = 5;
  localparam int unsigned NFEAT = 4;

  localparam logic [31:0] PERIOD_RST = 32'h001e8480;
  localparam logic [15:0] W_RST = 16'h0001;
  localparam logic [31:0] MAXDIFF_RST = 32'h00002710;

  typedef enum logic [1:0] {
    DCT_PR_IDLE = 2'b00,
    DCT_PR_HAVE_L = 2'b01,
    DCT_PR_HAVE_R = 2'b10
  } dct_pair_st_t;
endpackage : dct_pkg

// >>> design/dct_pulse.sv
// One pulse channel: rises when started, falls after a width in cycles.
// Assumes start is a one-cycle strobe on the system clock.
`timescale 1ns/1ps
`default_nettype none
module dct_pulse (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // Control
  input wire logic en_in,
  input wire logic start_in,
  input wire logic [31:0] width_in,
  // Output
  output logic pulse_out
);
  import dct_pkg::*;
  logic [31:0] cnt_q;

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_q <= 32'h0;
      pulse_out <= 1'b0;
    end else if (!en_in) begin
      cnt_q <= 32'h0;
      pulse_out <= 1'b0;
    end else if (start_in) begin
      cnt_q <= width_in;
      pulse_out <= (width_in != 32'h0);
    end else if (cnt_q > 32'h1) begin
      cnt_q <= cnt_q - 32'h1;
    end else begin
      cnt_q <= 32'h0;
      pulse_out <= 1'b0;
    end
  end
endmodule : dct_pulse
`default_nettype wire

// >>> design/dct_ts_clock.sv
// Free-running microsecond timestamp clock with a synchronous clear.
// Assumes the clear is a one-cycle strobe on the system clock.
`timescale 1ns/1ps
`default_nettype none
module dct_ts_clock (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // Control
  input wire logic clr_in,
  // Time
  output logic [31:0] ts_out
);
  import dct_pkg::*;
  logic [31:0] div_q;

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      div_q <= 32'h0;
      ts_out <= 32'h0;
    end else if (clr_in) begin
      div_q <= 32'h0;
      ts_out <= 32'h0;
    end else if (div_q == CYC_PER_US - 32'h1) begin
      div_q <= 32'h0;
      ts_out <= ts_out + 32'h1;
    end else begin
      div_q <= div_q + 32'h1;
    end
  end
endmodule : dct_ts_clock
`default_nettype wire

// >>> design/dct_top.sv
// Top of the dual camera trigger generator and frame pairing block.
// Assumes synchronous inputs and single-cycle register strobes.
`timescale 1ns/1ps
`default_nettype none
module dct_top (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // Register port
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // Shared secondary trigger / sync pin
  input wire logic pps_in,
  output logic trig1_oe_out,
  // Triggers
  output logic trig0_out,
  output logic trig1_out,
  // Frame arrivals
  input wire logic frame_l_in,
  input wire logic frame_r_in,
  output logic pair_valid_out,
  output logic [31:0] pair_ts_out,
  // Camera feature follow port
  input wire logic [dct_pkg::NFEAT*16-1:0] left_feat_in,
  output logic [dct_pkg::NFEAT*16-1:0] right_feat_out,
  output logic right_feat_wr_out
);
  import dct_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  logic en0_q, en1_q, pps_en_q, tts_q;
  logic [NFEAT-1:0] follow_left_setting_q;
  logic [NFEAT-1:0] left_auto_q;
  logic [31:0] period_q;
  logic [15:0] w0_ms_q, w1_ms_q, ofs_ms_q;
  logic [31:0] maxdiff_q;

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      en0_q <= 1'b0;
      en1_q <= 1'b0;
      pps_en_q <= 1'b0;
      tts_q <= 1'b0;
      period_q <= PERIOD_RST;
      w0_ms_q <= W_RST;
      w1_ms_q <= W_RST;
      ofs_ms_q <= 16'h0;
      maxdiff_q <= MAXDIFF_RST;
      follow_left_setting_q <= '0;
      left_auto_q <= '0;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        A_CTRL: begin
          // Secondary enable stored only beside the primary enable
          en0_q <= reg_wdata_in[B_EN0];
          en1_q <= reg_wdata_in[B_EN1] & reg_wdata_in[B_EN0];
          pps_en_q <= reg_wdata_in[B_PPS];
          tts_q <= reg_wdata_in[B_TTS];
        end
        A_PERIOD: begin
          // Clamp into the 0.1 Hz .. 50 Hz range
          if (reg_wdata_in < PER_MIN) period_q <= PER_MIN;
          else if (reg_wdata_in > PER_MAX) period_q <= PER_MAX;
          else period_q <= reg_wdata_in;
        end
        A_W0_MS: w0_ms_q <= reg_wdata_in[15:0];
        A_W1_MS: w1_ms_q <= reg_wdata_in[15:0];
        A_OFS_MS: ofs_ms_q <= reg_wdata_in[15:0];
        A_MAXDIFF: maxdiff_q <= reg_wdata_in;
        A_FEAT: begin
          follow_left_setting_q <= reg_wdata_in[NFEAT-1:0];
          left_auto_q <= reg_wdata_in[2*NFEAT-1:NFEAT];
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Period counter and derived widths
  logic [31:0] per_cnt_q;
  logic [31:0] ofs_cnt_q;
  logic ofs_run_q;
  logic start0, start1;
  logic [31:0] w0_cyc, w1_cyc, ofs_cyc;
  logic trig1_en;
  logic trig1_raw;

  ////////////////////////////////////////////////////////////////////////////
  // Derived widths and offset

  // Widths clamped below the period so a pulse always ends before the next
  function automatic logic [31:0] dct_clamp(input logic [15:0] ms, input logic [31:0] per);
    logic [47:0] c;
    c = 48'(ms) * 48'(CYC_PER_MS);
    if (c >= 48'(per)) dct_clamp = per - 32'h1;
    else dct_clamp = c[31:0];
  endfunction : dct_clamp

  always_comb begin
    w0_cyc = dct_clamp(w0_ms_q, period_q);
    w1_cyc = dct_clamp(w1_ms_q, period_q);
    // Offset shares the clamp so the secondary start stays inside the period
    ofs_cyc = dct_clamp(ofs_ms_q, period_q);
  end

  assign trig1_en = en1_q & en0_q & ~pps_en_q;
  // Counter idles at zero, so the first pulse follows the enable at once
  assign start0 = en0_q && (per_cnt_q == 32'h0);

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) per_cnt_q <= 32'h0;
    else if (!en0_q) per_cnt_q <= 32'h0;
    else if (per_cnt_q >= period_q - 32'h1) per_cnt_q <= 32'h0;
    else per_cnt_q <= per_cnt_q + 32'h1;
  end

  // Secondary start follows each primary start by the offset
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ofs_cnt_q <= 32'h0;
      ofs_run_q <= 1'b0;
    end else if (!trig1_en) begin
      // Dropping the enable cancels a pending secondary start
      ofs_run_q <= 1'b0;
      ofs_cnt_q <= 32'h0;
    end else if (start0) begin
      ofs_run_q <= 1'b1;
      ofs_cnt_q <= ofs_cyc;
    end else if (ofs_run_q && ofs_cnt_q != 32'h0) begin
      ofs_cnt_q <= ofs_cnt_q - 32'h1;
    end else begin
      ofs_run_q <= 1'b0;
    end
  end
  assign start1 = ofs_run_q && (ofs_cnt_q == 32'h0);

  dct_pulse u_p0 (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .en_in(en0_q),
    .start_in(start0),
    .width_in(w0_cyc),
    .pulse_out(trig0_out)
  );

  dct_pulse u_p1 (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .en_in(trig1_en),
    .start_in(start1),
    .width_in(w1_cyc),
    .pulse_out(trig1_raw)
  );

  // Pin turns into a sync input while pulse-per-second sync is on
  // Enable follows the sync choice one cycle late
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      trig1_out <= 1'b0;
      trig1_oe_out <= 1'b0;
    end else begin
      trig1_out <= trig1_raw & ~pps_en_q;
      trig1_oe_out <= ~pps_en_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timestamp clock and trigger stamp
  logic pps_d1_q;
  logic pps_rise;
  logic [31:0] ts_now;
  logic [31:0] last_trig_q;

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) pps_d1_q <= 1'b0;
    else pps_d1_q <= pps_in;
  end
  // Sync edges are ignored unless sync is enabled
  assign pps_rise = pps_en_q & pps_in & ~pps_d1_q;

  dct_ts_clock u_ts (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .clr_in(pps_rise),
    .ts_out(ts_now)
  );

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) last_trig_q <= 32'h0;
    else if (start0) last_trig_q <= ts_now;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame pairing
  dct_pair_st_t pst_q;
  logic [31:0] held_ts_q;
  logic [31:0] fr_ts;
  logic [31:0] diff;
  logic [31:0] pair_cnt_q;

  // Trigger stamp relies on cameras answering every pulse
  assign fr_ts = tts_q ? last_trig_q : ts_now;
  // Distance is symmetric: either camera may deliver first
  assign diff = (fr_ts >= held_ts_q) ? fr_ts - held_ts_q : held_ts_q - fr_ts;

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pst_q <= DCT_PR_IDLE;
      held_ts_q <= 32'h0;
      pair_valid_out <= 1'b0;
      pair_ts_out <= 32'h0;
      pair_cnt_q <= 32'h0;
    end else begin
      pair_valid_out <= 1'b0;
      case (pst_q)
        DCT_PR_IDLE: begin
          held_ts_q <= fr_ts;
          // Both frames in one cycle pair at once
          if (frame_l_in && frame_r_in) begin
            pair_valid_out <= 1'b1;
            pair_ts_out <= fr_ts;
            pair_cnt_q <= pair_cnt_q + 32'h1;
          end else if (frame_l_in) pst_q <= DCT_PR_HAVE_L;
          else if (frame_r_in) pst_q <= DCT_PR_HAVE_R;
        end
        DCT_PR_HAVE_L, DCT_PR_HAVE_R: begin
          if ((pst_q == DCT_PR_HAVE_L) ? frame_r_in : frame_l_in) begin
            if (diff <= maxdiff_q) begin
              pair_valid_out <= 1'b1;
              pair_ts_out <= held_ts_q;
              pair_cnt_q <= pair_cnt_q + 32'h1;
              pst_q <= DCT_PR_IDLE;
            end else begin
              // Stale partner dropped; newer frame waits instead
              held_ts_q <= fr_ts;
              pst_q <= (pst_q == DCT_PR_HAVE_L) ? DCT_PR_HAVE_R : DCT_PR_HAVE_L;
            end
          end else if ((pst_q == DCT_PR_HAVE_L) ? frame_l_in : frame_r_in) begin
            // Same-side repeat replaces the held stamp
            held_ts_q <= fr_ts;
          end
        end
        default: pst_q <= DCT_PR_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Feature follow: copy left values where right follows an auto left
  logic [NFEAT*16-1:0] right_q;
  logic [NFEAT-1:0] copy;
  assign copy = follow_left_setting_q & left_auto_q;

  generate
    for (genvar i = 0; i < NFEAT; i++) begin : g_feat
      // Follow wins over a software write in the same cycle
      always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) right_q[i*16 +: 16] <= 16'h0;
        else if (copy[i]) right_q[i*16 +: 16] <= left_feat_in[i*16 +: 16];
        else if (reg_wr_in && reg_addr_in == A_RIGHT_SET && reg_wdata_in[19:16] == 4'(i))
          right_q[i*16 +: 16] <= reg_wdata_in[15:0];
      end
    end
  endgenerate

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      right_feat_out <= '0;
      right_feat_wr_out <= 1'b0;
    end else begin
      right_feat_out <= right_q;
      right_feat_wr_out <= (right_q != right_feat_out);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port: data stands in the cycle after the strobe
  // Zero outside that cycle, so nothing stale is mistaken for an answer
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) reg_rdata_out <= 32'h0;
    else if (reg_rd_in) begin
      case (reg_addr_in)
        A_CTRL: reg_rdata_out <= {28'h0, tts_q, pps_en_q, en1_q, en0_q};
        A_PERIOD: reg_rdata_out <= period_q;
        A_W0_MS: reg_rdata_out <= {16'h0, w0_ms_q};
        A_W1_MS: reg_rdata_out <= {16'h0, w1_ms_q};
        A_OFS_MS: reg_rdata_out <= {16'h0, ofs_ms_q};
        A_MAXDIFF: reg_rdata_out <= maxdiff_q;
        A_TSTAMP: reg_rdata_out <= ts_now;
        A_LAST_TRIG: reg_rdata_out <= last_trig_q;
        A_PAIR: reg_rdata_out <= pair_cnt_q;
        A_FEAT: reg_rdata_out <= {24'h0, left_auto_q, follow_left_setting_q};
        default: reg_rdata_out <= 32'h0;
      endcase
    end else reg_rdata_out <= 32'h0;
  end
endmodule : dct_top
`default_nettype wire

// >>> dv/dct_cam_model.sv
// Stereo camera pair: each camera answers every trigger rise with a frame.
// Assumes the delays hold steady while a frame is pending.
`timescale 1ns/1ps
`default_nettype none
module dct_cam_model (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // Trigger, manual shot, exposure delays
  input wire logic trig_in,
  input wire logic kick_in,
  input wire logic [15:0] dl_in,
  input wire logic [15:0] dr_in,
  // Frame arrivals
  output logic frame_l_out,
  output logic frame_r_out
);
  logic trig_q;
  logic [16:0] cl_q;
  logic [16:0] cr_q;
  wire logic go = (trig_in & ~trig_q) | kick_in;
  ////////////////////////////////////////////////////////////////////////////
  // No skipping: every rise restarts both exposures
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      trig_q <= 1'b0;
      cl_q <= 17'h0;
      cr_q <= 17'h0;
    end else begin
      trig_q <= trig_in;
      cl_q <= go ? {1'b0, dl_in} + 17'h1 : cl_q - {16'h0, cl_q != 17'h0};
      cr_q <= go ? {1'b0, dr_in} + 17'h1 : cr_q - {16'h0, cr_q != 17'h0};
    end
  end
  assign frame_l_out = cl_q == 17'h1;
  assign frame_r_out = cr_q == 17'h1;
endmodule : dct_cam_model
`default_nettype wire

// >>> dv/dct_top_chk.sv
// Port checker for the trigger and pairing top.
// Assumes binding to dct_top; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module dct_top_chk (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // Watched ports
  input wire logic trig0_out,
  input wire logic trig1_out,
  input wire logic trig1_oe_out,
  input wire logic frame_l_in,
  input wire logic frame_r_in,
  input wire logic pair_valid_out,
  input wire logic [dct_pkg::NFEAT*16-1:0] right_feat_out,
  input wire logic right_feat_wr_out
);
  import dct_pkg::*;
  logic [31:0] hi0_q;
  logic [31:0] hi1_q;
  logic [3:0] fr_q;
  logic seen0_q;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  ////////////////////////////////////////////////////////////////////////////
  // High times and age of the last frame
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      hi0_q <= 32'h0;
      hi1_q <= 32'h0;
      fr_q <= 4'hf;
      seen0_q <= 1'b0;
    end else begin
      hi0_q <= trig0_out ? hi0_q + 32'h1 : 32'h0;
      hi1_q <= trig1_out ? hi1_q + 32'h1 : 32'h0;
      fr_q <= (frame_l_in | frame_r_in) ? 4'h0 : fr_q + {3'h0, fr_q != 4'hf};
      seen0_q <= seen0_q | trig0_out;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  AST_T1_OE: assert property (!trig1_oe_out |-> !trig1_out)
    else $error("Secondary pulse with pin released");
  AST_T1_AFTER: assert property ($rose(trig1_out) |-> seen0_q || trig0_out)
    else $error("Secondary rise before any primary");
  AST_T0_WIDTH: assert property ($fell(trig0_out) |-> hi0_q >= CYC_PER_MS - 32'h1)
    else $error("Primary pulse too short");
  AST_T1_WIDTH: assert property ($fell(trig1_out) |-> hi1_q >= CYC_PER_MS - 32'h1)
    else $error("Secondary pulse too short");
  AST_T0_MAX: assert property (trig0_out |-> hi0_q < PER_MAX)
    else $error("Primary high beyond longest period");
  AST_PAIR_SRC: assert property (pair_valid_out |-> fr_q < 4'h8)
    else $error("Pair without a recent frame");
  AST_PAIR_ONE: assert property (pair_valid_out |=> !pair_valid_out)
    else $error("Pair strobe longer than a cycle");
  AST_FEAT_WR: assert property ($changed(right_feat_out) |-> ##[0:1] right_feat_wr_out)
    else $error("Right value changed without write");
  cover property ($rose(trig1_out));
  cover property (pair_valid_out);
  cover property (right_feat_wr_out);
endmodule : dct_top_chk
bind dct_top dct_top_chk dct_top_chk_i (.clk_sys_in, .rstn_in, .trig0_out, .trig1_out,
  .trig1_oe_out, .frame_l_in, .frame_r_in, .pair_valid_out, .right_feat_out, .right_feat_wr_out);
`default_nettype wire

// >>> dv/tb.sv
// Self-checking bench for the trigger and pairing block.
// Assumes the camera model answers every primary trigger rise.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dct_pkg::*;
  logic clk_sys_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [3:0] reg_addr_in = 4'h0;
  logic [31:0] reg_wdata_in = 32'h0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic pps_in = 1'b0;
  logic [NFEAT*16-1:0] left_feat_in = '0;
  logic [31:0] reg_rdata_out, pair_ts_out, rv, pts;
  logic trig1_oe_out, trig0_out, trig1_out, frame_l_in, frame_r_in;
  logic pair_valid_out, right_feat_wr_out;
  logic [NFEAT*16-1:0] right_feat_out;
  logic kick = 1'b0;
  logic t1_done = 1'b0;
  logic [15:0] dl = 16'h0;
  logic [15:0] dr = 16'h0;
  int num_errors = 0;
  int n_compared = 0;
  int cyc = 0, h0 = 0, h1 = 0, t0r = 0, t1r = 0, np = 0;
  logic [3:0] ra [8] = '{A_CTRL, A_PERIOD, A_W0_MS, A_W1_MS, A_OFS_MS, A_MAXDIFF, A_PAIR, 4'hb};
  logic [31:0] re [8] = '{32'h0, PERIOD_RST, 32'(W_RST), 32'(W_RST), 32'h0, MAXDIFF_RST,
    32'h0, 32'h0};
  dct_top dct_top_i (.clk_sys_in, .rstn_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .pps_in, .trig1_oe_out, .trig0_out, .trig1_out, .frame_l_in,
    .frame_r_in, .pair_valid_out, .pair_ts_out, .left_feat_in, .right_feat_out,
    .right_feat_wr_out);
  dct_cam_model dct_cam_model_i (.clk_sys_in, .rstn_in, .trig_in(trig0_out), .kick_in(kick),
    .dl_in(dl), .dr_in(dr), .frame_l_out(frame_l_in), .frame_r_out(frame_r_in));
  initial begin
    forever #10 clk_sys_in = ~clk_sys_in;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Pulse widths and rise times, away from the active edge
  always @(negedge clk_sys_in) begin
    cyc++;
    h0 += int'(trig0_out);
    h1 += int'(trig1_out);
    np += int'(pair_valid_out);
    if (trig0_out === 1'b1 && t0r == 0) t0r = cyc;
    if (trig1_out === 1'b1 && t1r == 0) t1r = cyc;
    t1_done = t1r != 0 && trig1_out === 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
      num_errors++;
    end
  endtask : chk
  task conclude;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude
  task automatic wt(ref logic s, input int lim);
    for (int i = 0; i < lim && s !== 1'b1; i++) @(posedge clk_sys_in) #1;
    chk({31'h0, s}, 32'h1);
    if (s !== 1'b1) conclude();
  endtask : wt
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1 rv = reg_rdata_out;
  endtask : rd
  task rdc(input logic [3:0] a, input logic [31:0] e);
    rd(a);
    chk(rv, e);
  endtask : rdc
  // Manual shot; frames then wait out the pairing window
  task shot(input logic [15:0] l, input logic [15:0] r);
    dl <= l;
    dr <= r;
    kick <= 1'b1;
    @(posedge clk_sys_in);
    kick <= 1'b0;
    repeat (300) @(posedge clk_sys_in);
  endtask : shot
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    for (int i = 0; i < 8; i++) rdc(ra[i], re[i]);
    wr(A_CTRL, 32'h2);
    rdc(A_CTRL, 32'h0);
    repeat (20) @(posedge clk_sys_in);
    chk(32'(h1), 32'h0);
    wr(A_PERIOD, 32'h1);
    rdc(A_PERIOD, PER_MIN);
    wr(A_PERIOD, 32'hffffffff);
    rdc(A_PERIOD, PER_MAX);
    wr(A_PERIOD, PER_MIN);
    $display("test registers done");
    wr(A_CTRL, 32'h4);
    rd(A_TSTAMP);
    chk(32'(rv != 32'h0), 32'h1);
    chk({31'h0, trig1_oe_out}, 32'h0);
    pps_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    pps_in <= 1'b0;
    rdc(A_TSTAMP, 32'h0);
    wr(A_CTRL, 32'h0);
    repeat (3) @(posedge clk_sys_in);
    chk({31'h0, trig1_oe_out}, 32'h1);
    $display("test sync done");
    // Half of the roughly 6 us spacing between manual shots
    wr(A_MAXDIFF, 32'h3);
    shot(16'd0, 16'd100);
    chk(32'(np), 32'h1);
    shot(16'd0, 16'd200);
    chk(32'(np), 32'h1);
    rdc(A_PAIR, 32'h1);
    $display("test pairing done");
    dl <= 16'd10;
    dr <= 16'd30;
    wr(A_W1_MS, 32'h2);
    // Zero window: the stale right frame left by the shots can never pair
    wr(A_MAXDIFF, 32'h0);
    wr(A_CTRL, 32'hb);
    wt(pair_valid_out, 500);
    pts = pair_ts_out;
    rdc(A_LAST_TRIG, pts);
    wt(t1_done, 100200);
    chk(32'(h0), CYC_PER_MS);
    chk(32'(h1), 2 * CYC_PER_MS);
    chk(32'(t1r >= t0r && t1r - t0r <= 3), 32'h1);
    $display("test triggers done");
    wr(A_FEAT, 32'h1);
    left_feat_in <= 64'h1234;
    repeat (20) @(posedge clk_sys_in);
    chk(right_feat_out[31:0], 32'h0);
    wr(A_FEAT, 32'h11);
    wt(right_feat_wr_out, 20);
    chk(right_feat_out[31:0], 32'h1234);
    $display("test follow done");
    conclude();
  end
endmodule : tb
`default_nettype wire
